//--- vbta_cfg.svh
/*
  Register offsets, field positions and reset values of the rail threshold
  and alarm register bank. Assumes byte-wide registers at 8-bit addresses.
*/
`ifndef VBTA_CFG_SVH
`define VBTA_CFG_SVH

`define VBTA_OFS_THR_BASE 8'h72
`define VBTA_OFS_SNK_LO 8'h72
`define VBTA_OFS_SNK_HI 8'h73
`define VBTA_OFS_STOP_LO 8'h74
`define VBTA_OFS_STOP_HI 8'h75
`define VBTA_OFS_OVER_LO 8'h76
`define VBTA_OFS_OVER_HI 8'h77
`define VBTA_OFS_UNDER_LO 8'h78
`define VBTA_OFS_UNDER_HI 8'h79
`define VBTA_OFS_VSTAT 8'h90
`define VBTA_OFS_VMASK 8'h92

`define VBTA_BIT_TIMER 4
`define VBTA_BIT_CFGOV 3
`define VBTA_BIT_OTEMP 2

`define VBTA_RST_THR_LO 8'h00
`define VBTA_RST_THR_HI 2'h0
`define VBTA_RST_VSTAT 3'h0
`define VBTA_RST_VMASK 3'h0
`define VBTA_RST_BYTE 8'h00

`define VBTA_IDX_SNK 0
`define VBTA_IDX_STOP 1
`define VBTA_IDX_OVER 2
`define VBTA_IDX_UNDER 3
`define VBTA_NUM_THR 4

`endif

//--- vbta_pkg.sv
/*
  Types of the rail threshold and alarm register bank.
  Assumes the constants of vbta_cfg.svh.
*/
`default_nettype none
package vbta_pkg;

  typedef enum logic [1:0] {
    VBTA_DS_IDLE = 2'b00,
    VBTA_DS_SRC = 2'b01,
    VBTA_DS_SNK = 2'b10
  } vbta_dis_e;

  typedef struct packed {
    logic [7:0] lo;
    logic [1:0] hi;
  } vbta_thr_s;

  typedef struct packed {
    logic rp_s1;
    logic rp_s2;
    logic ot_s1;
    logic ot_s2;
    logic cf_s1;
    logic cf_s2;
    logic snk_armed;
    vbta_dis_e ds;
    logic detach;
    logic over;
    logic under;
    logic [2:0] vstat;
    logic [2:0] vmask;
    logic [7:0] rdata;
  } vbta_main_s;

endpackage
`default_nettype wire

//--- vbta_thr_if.sv
/*
  Carrier between the bank and one 10-bit threshold register pair.
  Assumes writes come from the bank's own byte register port.
*/
`timescale 1ns/1ps
`default_nettype none
interface vbta_thr_if;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] wdata;
  logic [9:0] level;
  modport owner (input wr_lo, input wr_hi, input wdata, output level);
  modport user (output wr_lo, output wr_hi, output wdata, input level);
endinterface
`default_nettype wire

//--- vbta_thr_reg.sv
/*
  One 10-bit threshold held as a low byte and two upper bits.
  Assumes write strobes are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vbta_cfg.svh"
module vbta_thr_reg
  import vbta_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  vbta_thr_if.owner bus
);

  vbta_thr_s q;
  vbta_thr_s next_q;

  always_comb begin
    next_q = q;
    if (bus.wr_lo) begin
      next_q.lo = bus.wdata;
    end
    if (bus.wr_hi) begin
      next_q.hi = bus.wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{lo: `VBTA_RST_THR_LO, hi: `VBTA_RST_THR_HI};
    end else begin
      q <= next_q;
    end
  end

  // Both bytes form one value, so comparisons always see the full code.
  assign bus.level = {q.hi, q.lo};

endmodule
`default_nettype wire

//--- vbta_regs.sv
/*
  Rail threshold and alarm register bank with detach, discharge and alarm
  comparisons, plus the extra interrupt status and mask registers.
  Assumes a byte register port driven by the serial front end on clk, and
  rail samples produced on clk with a one-cycle valid strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vbta_cfg.svh"
module vbta_regs
  import vbta_pkg::*;
#(
  parameter logic [9:0] VSAFE0V_LEVEL = 10'h020
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [9:0] rail_sample,
  input wire logic rail_sample_valid,
  input wire logic rail_present_flag,
  input wire logic rail_source,
  input wire logic auto_discharge_en,
  input wire logic discharge_req,
  input wire logic rail_alarm_off,
  input wire logic read_clear,
  input wire logic slow_osc_timer_expired,
  input wire logic config_pin_overvolt,
  input wire logic port_attached,
  input wire logic overtemp_shutdown,
  output logic sink_detach,
  output logic discharge_en,
  output logic rail_over_flag,
  output logic rail_under_flag,
  output logic extra_irq
);

  vbta_main_s q;
  vbta_main_s next_q;
  vbta_thr_if thr[`VBTA_NUM_THR] ();
  logic [9:0] snk_lvl;
  logic [9:0] stop_lvl;
  logic [9:0] over_lvl;
  logic [9:0] under_lvl;

  // Each pair sits at two consecutive addresses, low byte first, so the
  // decode is the base plus twice the pair index.
  genvar gi;
  generate
    for (gi = 0; gi < `VBTA_NUM_THR; gi++) begin : g_thr
      assign thr[gi].wdata = reg_wdata;
      assign thr[gi].wr_lo = reg_wr &&
        (reg_addr == 8'(`VBTA_OFS_THR_BASE + 2 * gi));
      assign thr[gi].wr_hi = reg_wr &&
        (reg_addr == 8'(`VBTA_OFS_THR_BASE + 2 * gi + 1));
      vbta_thr_reg u_thr (
        .clk(clk),
        .arst_n(arst_n),
        .bus(thr[gi])
      );
    end
  endgenerate

  assign snk_lvl = thr[`VBTA_IDX_SNK].level;
  assign stop_lvl = thr[`VBTA_IDX_STOP].level;
  assign over_lvl = thr[`VBTA_IDX_OVER].level;
  assign under_lvl = thr[`VBTA_IDX_UNDER].level;

  logic use_thr;
  logic [7:0] rd_mux;
  logic [2:0] set_v;
  logic [2:0] clr_v;
  logic [9:0] end_lvl;

  always_comb begin
    // A zero level disables the compare and hands detach back to presence.
    use_thr = (snk_lvl != 10'h000) && auto_discharge_en;

    // Read data is captured into a flop on the strobe, so it holds steady
    // until the next read even while status bits keep moving.
    case (reg_addr)
      `VBTA_OFS_SNK_LO: rd_mux = snk_lvl[7:0];
      `VBTA_OFS_SNK_HI: rd_mux = {6'h00, snk_lvl[9:8]};
      `VBTA_OFS_STOP_LO: rd_mux = stop_lvl[7:0];
      `VBTA_OFS_STOP_HI: rd_mux = {6'h00, stop_lvl[9:8]};
      `VBTA_OFS_OVER_LO: rd_mux = over_lvl[7:0];
      `VBTA_OFS_OVER_HI: rd_mux = {6'h00, over_lvl[9:8]};
      `VBTA_OFS_UNDER_LO: rd_mux = under_lvl[7:0];
      `VBTA_OFS_UNDER_HI: rd_mux = {6'h00, under_lvl[9:8]};
      `VBTA_OFS_VSTAT: rd_mux = {3'h0, q.vstat, 2'h0};
      `VBTA_OFS_VMASK: rd_mux = {3'h0, q.vmask, 2'h0};
      default: rd_mux = `VBTA_RST_BYTE;
    endcase

    // Status bits 4:2 sit at vector positions 2:0; the pin sources feeding
    // bits 3 and 2 are only read after their second synchroniser stage.
    set_v = 3'h0;
    set_v[`VBTA_BIT_TIMER - 2] = slow_osc_timer_expired;
    set_v[`VBTA_BIT_CFGOV - 2] = q.cf_s2 && !port_attached;
    set_v[`VBTA_BIT_OTEMP - 2] = q.ot_s2;

    clr_v = 3'h0;
    if (!read_clear && reg_wr && reg_addr == `VBTA_OFS_VSTAT) begin
      clr_v = reg_wdata[4:2];
    end
    if (read_clear && reg_rd && reg_addr == `VBTA_OFS_VSTAT) begin
      clr_v = 3'h7;
    end

    // Stop level only applies to a source discharge; sink always goes low.
    if (q.ds == VBTA_DS_SRC && stop_lvl != 10'h000) begin
      end_lvl = stop_lvl;
    end else begin
      end_lvl = VSAFE0V_LEVEL;
    end

    next_q = q;
    // The presence, overtemperature and config-pin flags pass two flops before any logic looks at them.
    next_q.rp_s1 = rail_present_flag;
    next_q.rp_s2 = q.rp_s1;
    next_q.ot_s1 = overtemp_shutdown;
    next_q.ot_s2 = q.ot_s1;
    next_q.cf_s1 = config_pin_overvolt;
    next_q.cf_s2 = q.cf_s1;
    next_q.detach = 1'b0;
    next_q.over = 1'b0;
    next_q.under = 1'b0;
    // A flag that sets in the clearing cycle stays set.
    next_q.vstat = (q.vstat & ~clr_v) | set_v;
    if (reg_wr && reg_addr == `VBTA_OFS_VMASK) begin
      next_q.vmask = reg_wdata[4:2];
    end
    if (reg_rd) begin
      next_q.rdata = rd_mux;
    end

    if (rail_sample_valid) begin
      next_q.over = !rail_alarm_off && (rail_sample > over_lvl);
      next_q.under = !rail_alarm_off && (rail_sample < under_lvl);
    end

    // Arming keeps one detach per attach rather than one per low sample.
    if (!rail_source) begin
      if (use_thr) begin
        if (rail_sample_valid) begin
          if (rail_sample >= snk_lvl) begin
            next_q.snk_armed = 1'b1;
          end else if (q.snk_armed) begin
            next_q.snk_armed = 1'b0;
            next_q.detach = 1'b1;
          end
        end
      end else if (q.rp_s2) begin
        next_q.snk_armed = 1'b1;
      end else if (q.snk_armed) begin
        next_q.snk_armed = 1'b0;
        next_q.detach = 1'b1;
      end
    end else begin
      next_q.snk_armed = 1'b0;
    end

    // A sink detach outranks a source request; both cannot hold at once
    // because a detach is only raised in the sink role.
    case (q.ds)
      VBTA_DS_IDLE: begin
        if (next_q.detach && auto_discharge_en) begin
          next_q.ds = VBTA_DS_SNK;
        end else if (rail_source && discharge_req) begin
          next_q.ds = VBTA_DS_SRC;
        end
      end
      VBTA_DS_SRC, VBTA_DS_SNK: begin
        if (rail_sample_valid && rail_sample <= end_lvl) begin
          next_q.ds = VBTA_DS_IDLE;
        end
      end
      default: next_q.ds = VBTA_DS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{rp_s1: 1'b0, rp_s2: 1'b0, ot_s1: 1'b0, ot_s2: 1'b0,
             cf_s1: 1'b0, cf_s2: 1'b0, snk_armed: 1'b0,
             ds: VBTA_DS_IDLE, detach: 1'b0, over: 1'b0, under: 1'b0,
             vstat: `VBTA_RST_VSTAT, vmask: `VBTA_RST_VMASK,
             rdata: `VBTA_RST_BYTE};
    end else begin
      q <= next_q;
    end
  end

  // Alarm flags are single-cycle set pulses for an outer alert register.
  assign reg_rdata = q.rdata;
  assign sink_detach = q.detach;
  assign discharge_en = (q.ds != VBTA_DS_IDLE);
  assign rail_over_flag = q.over;
  assign rail_under_flag = q.under;
  assign extra_irq = |(q.vstat & q.vmask);

endmodule
`default_nettype wire

//--- vbta_host.sv
/* Host model of the byte register port.
   Assumes requests are taken on the rising clk edge. */
`timescale 1ns/1ps
`default_nettype none
module vbta_host (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk) #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

//--- vbta_regs_asserts.sv
/* Port checker of the rail threshold bank.
   Assumes it is bound onto vbta_regs. */
`timescale 1ns/1ps
`default_nettype none
module vbta_regs_asserts (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rail_sample_valid,
  input wire logic rail_alarm_off,
  input wire logic auto_discharge_en,
  input wire logic slow_osc_timer_expired,
  input wire logic sink_detach,
  input wire logic discharge_en,
  input wire logic rail_over_flag,
  input wire logic rail_under_flag,
  input wire logic extra_irq
);
  logic [2:0] msk;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      msk <= 3'h0;
    else if (reg_wr && reg_addr == 8'h92)
      msk <= reg_wdata[4:2];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence rd_hi;
    reg_rd && reg_addr[7:4] == 4'h7 && reg_addr[0];
  endsequence
  sequence rd_stat;
    reg_rd && reg_addr == 8'h90;
  endsequence
  over_cause_a: assert property (rail_over_flag |->
    $past(rail_sample_valid && !rail_alarm_off)) else $error("over flag");
  under_cause_a: assert property (rail_under_flag |->
    $past(rail_sample_valid && !rail_alarm_off)) else $error("under flag");
  hi_reserved_a: assert property (rd_hi |=> reg_rdata[7:2] == 6'h00)
    else $error("high byte reserved bits");
  stat_reserved_a: assert property (rd_stat |=> reg_rdata[7:5] == 3'h0
    && reg_rdata[1:0] == 2'h0) else $error("status reserved bits");
  rdata_hold_a: assert property ($changed(reg_rdata) |-> $past(reg_rd))
    else $error("read data moved");
  irq_masked_a: assert property (msk == 3'h0 |-> !extra_irq)
    else $error("irq while masked");
  timer_irq_a: assert property (slow_osc_timer_expired ##1 msk[2]
    |-> extra_irq) else $error("timer irq missing");
  detach_dis_a: assert property (sink_detach && $past(auto_discharge_en)
    |-> discharge_en) else $error("no discharge on detach");
endmodule
bind vbta_regs vbta_regs_asserts u_asserts (
  .clk(clk),
  .arst_n(arst_n),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_wdata(reg_wdata),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .rail_sample_valid(rail_sample_valid),
  .rail_alarm_off(rail_alarm_off),
  .auto_discharge_en(auto_discharge_en),
  .slow_osc_timer_expired(slow_osc_timer_expired),
  .sink_detach(sink_detach),
  .discharge_en(discharge_en),
  .rail_over_flag(rail_over_flag),
  .rail_under_flag(rail_under_flag),
  .extra_irq(extra_irq)
);
`default_nettype wire

//--- vbta_regs_bench.sv
/* Self-checking bench of the rail threshold bank.
   Assumes vbta_host drives the register port. */
`timescale 1ns/1ps
`default_nettype none
module vbta_regs_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic reg_wr, reg_rd, sink_detach, discharge_en, seen;
  logic rail_over_flag, rail_under_flag, extra_irq;
  logic [9:0] rail_sample = 10'h000;
  logic rail_sample_valid = 1'b0, rail_present_flag = 1'b0;
  logic rail_source = 1'b0, auto_discharge_en = 1'b0;
  logic discharge_req = 1'b0, rail_alarm_off = 1'b0, read_clear = 1'b0;
  logic slow_osc_timer_expired = 1'b0, config_pin_overvolt = 1'b0;
  logic port_attached = 1'b1, overtemp_shutdown = 1'b0;
  int fails = 0;
  int checks_done = 0;
  always #10 clk = ~clk;
  vbta_regs dut (
    .clk(clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .rail_sample(rail_sample),
    .rail_sample_valid(rail_sample_valid),
    .rail_present_flag(rail_present_flag),
    .rail_source(rail_source),
    .auto_discharge_en(auto_discharge_en),
    .discharge_req(discharge_req),
    .rail_alarm_off(rail_alarm_off),
    .read_clear(read_clear),
    .slow_osc_timer_expired(slow_osc_timer_expired),
    .config_pin_overvolt(config_pin_overvolt),
    .port_attached(port_attached),
    .overtemp_shutdown(overtemp_shutdown),
    .sink_detach(sink_detach),
    .discharge_en(discharge_en),
    .rail_over_flag(rail_over_flag),
    .rail_under_flag(rail_under_flag),
    .extra_irq(extra_irq)
  );
  vbta_host host (
    .clk(clk),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );
  task automatic end_sim;
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chkf(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t outputs %b exp %b", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    checks_done++;
    if (rv !== exp) begin
      fails++;
      $display("CHECK FAILED %0t reg %h got %h exp %h", $time, a, rv, exp);
    end
  endtask
  task automatic samp(input logic [9:0] v);
    @(posedge clk) #1;
    rail_sample = v;
    rail_sample_valid = 1'b1;
    @(posedge clk) #1;
    rail_sample_valid = 1'b0;
  endtask
  task automatic sa(input logic [9:0] v, input logic [1:0] e);
    samp(v);
    chkf({rail_over_flag, rail_under_flag}, e);
  endtask
  task automatic sd(input logic [9:0] v, input logic [1:0] e);
    samp(v);
    chkf({sink_detach, discharge_en}, e);
  endtask
  task automatic pulse_req;
    @(posedge clk) #1 discharge_req = 1'b1;
    @(posedge clk) #1 discharge_req = 1'b0;
  endtask
  task automatic t_regs;
    for (int a = 8'h72; a <= 8'h7a; a++) begin
      rdc(8'(a), 8'h00);
      host.wr(8'(a), 8'hff);
      rdc(8'(a), a == 8'h7a ? 8'h00 : a[0] ? 8'h03 : 8'hff);
    end
  endtask
  task automatic t_alarm;
    host.wr(8'h76, 8'h00);
    host.wr(8'h77, 8'h00);
    host.wr(8'h78, 8'h50);
    host.wr(8'h79, 8'h00);
    sa(10'h001, 2'b11);
    host.wr(8'h76, 8'ha0);
    host.wr(8'h77, 8'h01);
    sa(10'h190, 2'b00);
    sa(10'h1a1, 2'b10);
    sa(10'h1a0, 2'b00);
    sa(10'h04f, 2'b01);
    rail_alarm_off = 1'b1;
    sa(10'h3ff, 2'b00);
    sa(10'h001, 2'b00);
    rail_alarm_off = 1'b0;
  endtask
  task automatic t_status;
    host.wr(8'h92, 8'hff);
    rdc(8'h92, 8'h1c);
    @(posedge clk) #1 slow_osc_timer_expired = 1'b1;
    @(posedge clk) #1 slow_osc_timer_expired = 1'b0;
    chkf({extra_irq, 1'b0}, 2'b10);
    rdc(8'h90, 8'h10);
    host.wr(8'h90, 8'h08);
    rdc(8'h90, 8'h10);
    host.wr(8'h90, 8'h10);
    rdc(8'h90, 8'h00);
    config_pin_overvolt = 1'b1;
    repeat (6) @(posedge clk);
    rdc(8'h90, 8'h00);
    port_attached = 1'b0;
    overtemp_shutdown = 1'b1;
    repeat (6) @(posedge clk);
    #1 config_pin_overvolt = 1'b0;
    overtemp_shutdown = 1'b0;
    host.wr(8'h92, 8'h00);
    repeat (4) @(posedge clk);
    #1 chkf({extra_irq, 1'b0}, 2'b00);
    read_clear = 1'b1;
    host.wr(8'h90, 8'h0c);
    rdc(8'h90, 8'h0c);
    rdc(8'h90, 8'h00);
    read_clear = 1'b0;
    port_attached = 1'b1;
  endtask
  task automatic t_detach;
    host.wr(8'h74, 8'h00);
    host.wr(8'h75, 8'h01);
    host.wr(8'h73, 8'h00);
    host.wr(8'h72, 8'hc8);
    auto_discharge_en = 1'b1;
    sd(10'h0d0, 2'b00);
    sd(10'h0c8, 2'b00);
    sd(10'h0c7, 2'b11);
    sd(10'h0c0, 2'b01);
    samp(10'h020);
    sd(10'h100, 2'b00);
    host.wr(8'h72, 8'h00);
    rail_present_flag = 1'b1;
    sd(10'h000, 2'b00);
    rail_present_flag = 1'b0;
    seen = 1'b0;
    repeat (6) @(posedge clk) #1 seen |= sink_detach;
    chkf({seen, 1'b0}, 2'b10);
    samp(10'h000);
  endtask
  task automatic t_src;
    auto_discharge_en = 1'b0;
    rail_source = 1'b1;
    pulse_req();
    sd(10'h101, 2'b01);
    samp(10'h100);
    sd(10'h3ff, 2'b00);
    host.wr(8'h75, 8'h00);
    pulse_req();
    sd(10'h030, 2'b01);
    samp(10'h020);
    sd(10'h3ff, 2'b00);
  endtask
  initial begin
    #51 arst_n = 1'b1;
    t_regs();
    t_alarm();
    t_status();
    t_detach();
    t_src();
    end_sim();
  end
  initial begin
    #100000;
    fails++;
    end_sim();
  end
endmodule
`default_nettype wire
